/* File: verilog/dlic_pkg.sv */
// dlic_pkg: register map, source layout and reset values of the dual level interrupt controller
package dlic_pkg;

   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 32;

   // register byte offsets
   localparam logic [7:0]  OFS_NRM_RAW    = 8'h00;
   localparam logic [7:0]  OFS_NRM_EN     = 8'h04;
   localparam logic [7:0]  OFS_NRM_CLR    = 8'h08;
   localparam logic [7:0]  OFS_NRM_STA    = 8'h0c;
   localparam logic [7:0]  OFS_FST_RAW    = 8'h10;
   localparam logic [7:0]  OFS_FST_EN     = 8'h14;
   localparam logic [7:0]  OFS_FST_CLR    = 8'h18;
   localparam logic [7:0]  OFS_FST_STA    = 8'h1c;
   localparam logic [7:0]  OFS_PROG_CFG   = 8'h20;

   // bit positions
   localparam int          BIT_FAST_OR    = 0;
   localparam int          BIT_PROG       = 1;
   localparam int          BIT_CFG_NRM    = 1;
   localparam int          BIT_CFG_FST    = 2;

   // peripheral source positions: bits 2..14 and 16..19
   localparam logic [31:0] SRC_MASK       = 32'h000f_7ffc;
   localparam logic [31:0] CFG_MASK       = 32'h0000_0006;

   localparam logic [31:0] RST_EN         = 32'h0000_0000;
   localparam logic [31:0] RST_CFG        = 32'h0000_0000;
   localparam logic [31:0] RST_RDATA      = 32'h0000_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } dlic_req_t;

endpackage

/* File: verilog/dlic_top.sv */
// dlic_top: dual level interrupt controller with normal and fast request outputs
//
// Functional notes
// RL1 - mask-clear write clears ones in normal enables
// RL2 - normal status equals raw AND enable; bit 0 takes the fast OR regardless of enable
// RL3 - set normal status bit drives normal request
// RL4 - no priority or vector generation
// RL5 - fast level mirrors normal register set
// RL6 - OR fast status 31:1 to fast request
// RL7 - fast enable set clears normal enable bit
// RL8 - normal enable set clears fast enable bit
// RL9 - source may be disabled at both levels
// RL10 - programmed interrupts bypass enables
// RL11 - config bit 2 drives fast bit 1
// RL12 - config bit 1 drives normal bit 1
// RL13 - sources hold request past minimum latency
// RL14 - raw bits follow peripheral request lines
// RL15 - enable write of zero has no effect
// RL16 - OR all normal status to normal request
// RL17 - seventeen sources, bit 15 reserved
// RL18 - config reserved bits read zero
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module dlic_top (
   input  wire logic                         sys_clk,
   input  wire logic                         rst,
   input  wire logic [dlic_pkg::ADDR_W-1:0]  addr,
   input  wire logic [dlic_pkg::DATA_W-1:0]  wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output logic      [dlic_pkg::DATA_W-1:0]  rdata,
   input  wire logic [31:0]                  src_irq,
   output logic                              normal_irq,
   output logic                              fast_interrupt_request
);

   ////////////////////////////////////////////////////////////////////////////
   dlic_pkg::dlic_req_t req;
   logic [31:0]         nrm_en_q, nrm_en_d;
   logic [31:0]         fst_en_q, fst_en_d;
   logic [31:0]         cfg_q, cfg_d;
   logic [31:0]         src_s1_q, src_q;
   logic [31:0]         rdata_d;
   logic [31:0]         nrm_raw, fst_raw, nrm_sta, fst_sta;
   logic                fast_or;
   logic                nrm_irq_d, fst_irq_d;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   function automatic logic hit(input dlic_pkg::dlic_req_t r, input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // source lines come from other logic; two stage sample keeps them clean
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         src_s1_q <= 32'h0000_0000;
         src_q    <= 32'h0000_0000;
      end else begin
         src_s1_q <= src_irq & dlic_pkg::SRC_MASK; // RL17
         src_q    <= src_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status and requests; no encoder, software picks the source
   always_comb begin
      fst_raw = src_q; // RL14
      fst_raw[dlic_pkg::BIT_PROG] = cfg_q[dlic_pkg::BIT_CFG_FST]; // RL11 RL10
      nrm_raw = src_q; // RL14
      nrm_raw[dlic_pkg::BIT_PROG] = cfg_q[dlic_pkg::BIT_CFG_NRM]; // RL12 RL10
      fst_sta = fst_raw & fst_en_q; // RL5
      fst_sta[dlic_pkg::BIT_PROG] = cfg_q[dlic_pkg::BIT_CFG_FST]; // RL11 RL10
      fast_or = |fst_sta[31:1]; // RL6
      fst_sta[dlic_pkg::BIT_FAST_OR] = fast_or; // RL6
      fst_raw[dlic_pkg::BIT_FAST_OR] = fast_or; // RL6
      nrm_raw[dlic_pkg::BIT_FAST_OR] = fast_or; // RL6
      nrm_sta = nrm_raw & nrm_en_q; // RL2
      nrm_sta[dlic_pkg::BIT_PROG] = cfg_q[dlic_pkg::BIT_CFG_NRM]; // RL12 RL10
      nrm_sta[dlic_pkg::BIT_FAST_OR] = fast_or; // RL6
      nrm_irq_d = |nrm_sta; // RL16 RL3 RL4
      fst_irq_d = fast_or; // RL6
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable masks and programmed config
   always_comb begin
      nrm_en_d = nrm_en_q;
      fst_en_d = fst_en_q;
      cfg_d    = cfg_q;
      if (req.wr) begin
         if (hit(req, dlic_pkg::OFS_NRM_EN)) begin
            nrm_en_d = nrm_en_q | req.wdata; // RL15
            fst_en_d = fst_en_q & ~req.wdata; // RL8 RL9
         end
         if (hit(req, dlic_pkg::OFS_NRM_CLR)) begin
            nrm_en_d = nrm_en_q & ~req.wdata; // RL1 RL9
         end
         if (hit(req, dlic_pkg::OFS_FST_EN)) begin
            fst_en_d = fst_en_q | req.wdata; // RL5
            nrm_en_d = nrm_en_q & ~req.wdata; // RL7 RL9
         end
         if (hit(req, dlic_pkg::OFS_FST_CLR)) begin
            fst_en_d = fst_en_q & ~req.wdata; // RL5
         end
         if (hit(req, dlic_pkg::OFS_PROG_CFG)) begin
            cfg_d = req.wdata & dlic_pkg::CFG_MASK; // RL18
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; write-only and unmapped offsets read zero
   always_comb begin
      rdata_d = dlic_pkg::RST_RDATA;
      if (req.rd) begin
         case (req.addr)
            dlic_pkg::OFS_NRM_RAW:  rdata_d = nrm_raw;
            dlic_pkg::OFS_NRM_EN:   rdata_d = nrm_en_q;
            dlic_pkg::OFS_NRM_STA:  rdata_d = nrm_sta;
            dlic_pkg::OFS_FST_RAW:  rdata_d = fst_raw;
            dlic_pkg::OFS_FST_EN:   rdata_d = fst_en_q;
            dlic_pkg::OFS_FST_STA:  rdata_d = fst_sta;
            dlic_pkg::OFS_PROG_CFG: rdata_d = cfg_q; // RL18
            default:                rdata_d = dlic_pkg::RST_RDATA;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         nrm_en_q               <= dlic_pkg::RST_EN;
         fst_en_q               <= dlic_pkg::RST_EN;
         cfg_q                  <= dlic_pkg::RST_CFG;
         rdata                  <= dlic_pkg::RST_RDATA;
         normal_irq             <= 1'b0;
         fast_interrupt_request <= 1'b0;
      end else begin
         nrm_en_q               <= nrm_en_d;
         fst_en_q               <= fst_en_d;
         cfg_q                  <= cfg_d;
         rdata                  <= rdata_d;
         normal_irq             <= nrm_irq_d;
         fast_interrupt_request <= fst_irq_d;
      end
   end

endmodule

/* File: dv/dlic_props.sv */
// dlic_props: port checker for dlic_top
`timescale 1ns/1ps
module dlic_props (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic [31:0] src_irq,
   input wire logic        normal_irq,
   input wire logic        fast_interrupt_request
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   clr_read_a: assert property (rd && addr == 8'h08 |=> rdata == 0)
      else $error("mask clear read");
   cfg_resv_a: assert property (rd && addr == 8'h20 |=> rdata[31:3] == 0 && !rdata[0])
      else $error("cfg reserved");
   fast_or_a: assert property (rd && addr == 8'h1c |=> rdata[0] == |rdata[31:1])
      else $error("fast or bit");
   nrm_bit0_a: assert property (rd && addr == 8'h0c |=> rdata[0] == fast_interrupt_request)
      else $error("normal bit 0");
   nrm_irq_a: assert property (rd && addr == 8'h0c |=> normal_irq == (rdata != 0))
      else $error("normal request");
   sw_fast_a: assert property (wr && addr == 8'h20 && wdata[2] |-> ##2 fast_interrupt_request)
      else $error("prog fast");
   sw_nrm_a: assert property (wr && addr == 8'h20 && wdata[1] |-> ##2 normal_irq)
      else $error("prog normal");
   rst_a: assert property (disable iff (1'b0) rst |=> !normal_irq && !fast_interrupt_request)
      else $error("reset");
   cover property (fast_interrupt_request);
   cover property (normal_irq && !fast_interrupt_request);
   cover property (wr && addr == 8'h08);
endmodule
bind dlic_top dlic_props dlic_props_i (.sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
   .src_irq, .normal_irq, .fast_interrupt_request);

/* File: dv/dlic_src_model.sv */
// dlic_src_model: peripheral request lines
`timescale 1ns/1ps
module dlic_src_model (
   input  wire logic        sys_clk,
   input  wire logic [31:0] want,
   output logic      [31:0] src_irq
);
   logic [31:0] held_q = '0;
   initial src_irq = '0;
   always @(posedge sys_clk) begin
      held_q <= want;
      src_irq <= want | held_q;
   end
endmodule

/* File: dv/dlic_top_tb.sv */
// dlic_top_tb: table-driven bench
`timescale 1ns/1ps
module dlic_top_tb;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} dlic_row_t;
   logic                sys_clk = 0;
   logic                rst = 1;
   logic [31:0]         want = 0;
   logic [31:0]         rdata, src_irq;
   logic                normal_irq, fast_interrupt_request;
   dlic_pkg::dlic_req_t q = '0;
   int                  errors = 0;
   int                  compares = 0;
   dlic_row_t           rows [26] = '{'{0,8'h00,'hc}, '{1,8'h04,'h4}, '{0,8'h04,'h4},
      '{0,8'h0c,'h4}, '{1,8'h14,'h8}, '{1,8'h04,'h8}, '{0,8'h14,'h0}, '{0,8'h04,'hc},
      '{1,8'h14,'h4}, '{0,8'h04,'h8}, '{0,8'h1c,'h5}, '{0,8'h0c,'h9}, '{1,8'h04,'h0},
      '{0,8'h04,'h8}, '{0,8'h08,'h0}, '{1,8'h08,'h8}, '{1,8'h18,'h4}, '{0,8'h04,'h0},
      '{0,8'h14,'h0}, '{1,8'h20,'hffffffff}, '{0,8'h20,'h6}, '{0,8'h00,'hf},
      '{0,8'h1c,'h3}, '{1,8'h20,'h0}, '{0,8'h20,'h0}, '{0,8'h0c,'h0}};
   always #2.5 sys_clk = ~sys_clk;
   dlic_src_model dlic_src_model_i (.sys_clk, .want, .src_irq);
   dlic_top dlic_top_i (.sys_clk, .rst, .addr(q.addr), .wdata(q.wdata), .wr(q.wr), .rd(q.rd),
      .rdata, .src_irq, .normal_irq, .fast_interrupt_request);
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s @%h exp %h got %h", n, q.addr, e, s);
      end
   endtask
   task wrt(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      q <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      q.wr <= 0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      q <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk);
      q.rd <= 0;
      #1 chk("rdata", rdata, e);
   endtask
   task summarize;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task waitirq(input logic e, input logic f);
      int n;
      for (n = 0; n < 20 && (normal_irq !== e || fast_interrupt_request !== f); n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("normal_irq", normal_irq, e);
      chk("fast_irq", fast_interrupt_request, f);
      if (n == 20) summarize();
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      want <= 32'hc;
      repeat (6) @(posedge sys_clk);
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wrt(rows[i].a, rows[i].d);
         end else begin
            rdc(rows[i].a, rows[i].d);
         end
      end
      wrt(8'h04, 32'h4);
      waitirq(1, 0);
      wrt(8'h08, 32'h4);
      waitirq(0, 0);
      wrt(8'h14, 32'h4);
      waitirq(1, 1);
      want <= 32'h0;
      waitirq(0, 0);
      rst <= 1;
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      rdc(8'h14, 32'h0);
      rdc(8'h20, 32'h0);
      summarize();
   end
endmodule
